/* File: core/prc_apd_unit.sv */
// Auto power-down counter, advanced on logic clock input rising edges.
// Assumes the strobe and clock inputs are already synchronous.
`timescale 1ns/1ps
module prc_apd_unit #(
  parameter int unsigned LIMIT = prc_pkg::APD_LIMIT
) (
  input  wire logic ref_clk,     // System clock
  input  wire logic rst,         // Async reset
  input  wire logic clk_in,      // Logic clock input level
  input  wire logic enable,      // Unit enable
  input  wire logic polarity,    // Idle strobe level
  input  wire logic strobe,      // Host address strobe
  input  wire logic wake,        // Chip select or reset wake
  output logic      power_down_flag          // power_down_flag
);
  typedef struct packed {
    logic       clk_d;
    logic       strb_d;
    logic [3:0] cnt;
    logic       power_down_flag;
  } prc_apd_s;
  prc_apd_s st_ff, nxt_st;
  logic     edge_seen;
  logic     pulsed;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.clk_d  = clk_in;
    nxt_st.strb_d = strobe;
    edge_seen = clk_in & ~st_ff.clk_d;
    pulsed    = strobe ^ st_ff.strb_d;
    if (!enable || pulsed || strobe != polarity) begin
      nxt_st.cnt = 4'h0;
      nxt_st.power_down_flag = 1'b0;
    end else if (edge_seen && st_ff.cnt != 4'(LIMIT)) begin
      nxt_st.cnt = st_ff.cnt + 4'h1;
    end
    if (enable && !pulsed && strobe == polarity && st_ff.cnt == 4'(LIMIT)) begin
      nxt_st.power_down_flag = 1'b1;
    end
    if (wake) begin
      nxt_st.cnt = 4'h0;
      nxt_st.power_down_flag = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign power_down_flag = st_ff.power_down_flag;
endmodule

/* File: core/prc_device.sv */
// Device end: power modes, input gating, memory enables, reset sequencing.
// Assumes host drives the link synchronously to ref_clk.
`timescale 1ns/1ps
module prc_device #(
  parameter int unsigned POR_CYC   = prc_pkg::POR_CYC,
  parameter int unsigned ABORT_CYC = prc_pkg::ABORT_CYC,
  parameter logic [7:0]  MMAP_CFG  = 8'h5a  // Stored configuration image
) (
  input  wire logic ref_clk,            // System clock
  input  wire logic rst,                // Async reset, supply power-on
  prc_link_if.dev   lnk,                // Link to host
  input  wire logic flash_start,        // Begin flash program/erase
  input  wire logic [7:0] mc_eq_state,  // Macrocell reset/preset equation state
  output logic      turbo_on,           // Logic at full power
  output logic      logic_standby,      // Logic at standby current
  output logic      clk_to_array,       // Gated logic clock to array
  output logic      clk_to_mc,          // Gated logic clock to macrocells
  output logic [7:0] array_addr,        // Gated low address byte
  output logic [4:0] array_ctl,         // Gated ctl0..2, strobe, wr_hi
  output logic      mem_en,             // Flashes and SRAM enabled
  output logic      io_en,              // I/O block enabled
  output logic [7:0] prim_sector_sel,   // primary_sector_selects
  output logic [3:0] sec_sector_sel,    // secondary_sector_selects
  output logic      flash_wr_n,         // Internal write strobe
  output logic      flash_read_mode,    // Flash in read mode
  output logic      cfg_loaded,         // Configuration loaded
  output logic      logic_out_valid,    // Logic outputs valid
  output logic [7:0] macrocell,         // output_macrocell flops
  output logic [7:0] mmap_reg           // memory_mapping_register
);
  typedef enum logic [1:0] {RS_POR, RS_WAIT, RS_RUN, RS_WARM} prc_rst_e;
  typedef struct packed {
    prc_rst_e   rs;
    logic [19:0] tmr;
    logic [7:0] pm0;
    logic [7:0] pm2;
    logic [7:0] mmap;
    logic [7:0] mc;
    logic [4:0] idle;
    logic [15:0] in_d;
    logic       busy;
    logic [19:0] abort;
    logic       cfg;
    logic       outs_valid;
    logic       turbo;
    logic       standby;
    logic       clk_and;
    logic       clk_mc;
    logic [7:0] a_g;
    logic [4:0] c_g;
    logic       mem;
    logic       io;
    logic [7:0] fs;
    logic [3:0] bs;
    logic       wr_n;
    logic       rd;
  } prc_dev_s;
  prc_dev_s st_ff, nxt_st;
  logic power_down_flag;
  logic op;
  logic [15:0] ins;

  prc_apd_unit u_apd (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .clk_in   (lnk.logic_clk_in),
    .enable   (lnk.apd_cfg[0]),
    .polarity (lnk.apd_cfg[1]),
    .strobe   (lnk.addr_strobe),
    .wake     (~lnk.chip_sel_n | ~lnk.reset_n),
    .power_down_flag      (power_down_flag)
  );

  always_comb begin
    nxt_st = st_ff;
    ins = {lnk.addr_lo, lnk.ctl_in, lnk.addr_strobe, lnk.wr_hi, lnk.logic_clk_in, 2'h0};
    op  = (st_ff.rs == RS_RUN);
    nxt_st.in_d = ins;
    // Reset sequencer
    case (st_ff.rs)
      RS_POR: begin
        nxt_st.cfg  = 1'b1;
        nxt_st.mmap = MMAP_CFG;
        nxt_st.mmap[prc_pkg::MM_SRAM_CODE] = 1'b0;
        nxt_st.mmap[prc_pkg::MM_PERIPH]    = 1'b0;
        nxt_st.rd = 1'b1;
        if (st_ff.tmr != 20'hfffff) nxt_st.tmr = st_ff.tmr + 20'h1;
        if (lnk.reset_n) begin
          nxt_st.rs  = RS_WAIT;
          nxt_st.tmr = '0;
        end
      end
      RS_WARM: begin
        nxt_st.mmap = MMAP_CFG;
        nxt_st.mmap[prc_pkg::MM_SRAM_CODE] = 1'b0;
        nxt_st.mmap[prc_pkg::MM_PERIPH]    = 1'b0;
        if (lnk.reset_n) begin
          nxt_st.rs  = RS_WAIT;
          nxt_st.tmr = '0;
        end
      end
      RS_WAIT: begin
        nxt_st.tmr = st_ff.tmr + 20'h1;
        // One cycle is lost sampling reset_n, so stop a cycle early
        if (st_ff.tmr >= 20'(prc_pkg::OPR_CYC - 2)) nxt_st.rs = RS_RUN;
        if (!lnk.reset_n) nxt_st.rs = RS_WARM;
      end
      RS_RUN: begin
        if (!lnk.reset_n) begin
          nxt_st.rs  = RS_WARM;
          nxt_st.tmr = '0;
        end
      end
      default: nxt_st.rs = RS_POR;
    endcase
    // Power-mode registers, unchanged by warm reset
    if (op && lnk.pm0_we) nxt_st.pm0 = lnk.pm_wdata;
    if (op && lnk.pm2_we) nxt_st.pm2 = lnk.pm_wdata;
    // Flash cycle and reset abort
    if (op && flash_start && !st_ff.busy) begin
      nxt_st.busy = 1'b1;
      nxt_st.rd   = 1'b0;
    end
    if (!lnk.reset_n && st_ff.busy) begin
      nxt_st.busy  = 1'b0;
      nxt_st.rd    = 1'b1;
      nxt_st.abort = 20'(ABORT_CYC);
    end else if (st_ff.abort != '0) begin
      nxt_st.abort = st_ff.abort - 20'h1;
    end
    // Macrocells follow their equations except during power-on
    nxt_st.mc = (st_ff.rs == RS_POR) ? 8'h00 : mc_eq_state;
    nxt_st.outs_valid = st_ff.cfg;
    nxt_st.turbo = ~st_ff.pm0[prc_pkg::PM0_TURBO_OFF];
    // Standby once turbo is off and inputs quiet for the idle interval
    if (ins != st_ff.in_d || st_ff.turbo) nxt_st.idle = '0;
    else if (st_ff.idle != 5'(prc_pkg::IDLE_CYC)) nxt_st.idle = st_ff.idle + 5'h1;
    nxt_st.standby = ~st_ff.turbo && st_ff.idle == 5'(prc_pkg::IDLE_CYC);
    nxt_st.clk_and = lnk.logic_clk_in & ~st_ff.pm0[prc_pkg::PM0_CLK_AND];
    nxt_st.clk_mc  = lnk.logic_clk_in & ~st_ff.pm0[prc_pkg::PM0_CLK_MC];
    nxt_st.a_g = (power_down_flag || st_ff.pm2[prc_pkg::PM2_ADDR_LO]) ? 8'h00 : lnk.addr_lo;
    nxt_st.c_g[0] = lnk.ctl_in[0] & ~st_ff.pm2[prc_pkg::PM2_CTL0] & ~power_down_flag;
    nxt_st.c_g[1] = lnk.ctl_in[1] & ~st_ff.pm2[prc_pkg::PM2_CTL1] & ~power_down_flag;
    nxt_st.c_g[2] = lnk.ctl_in[2] & ~st_ff.pm2[prc_pkg::PM2_CTL2] & ~power_down_flag;
    nxt_st.c_g[3] = lnk.addr_strobe & ~st_ff.pm2[prc_pkg::PM2_STROBE];
    nxt_st.c_g[4] = lnk.wr_hi & ~st_ff.pm2[prc_pkg::PM2_WRH] & ~power_down_flag;
    nxt_st.mem = op && !lnk.chip_sel_n && !power_down_flag;
    nxt_st.io  = !lnk.chip_sel_n;
    // Selects low and write high while not running
    nxt_st.fs   = nxt_st.mem ? 8'hff : 8'h00;
    nxt_st.bs   = nxt_st.mem ? 4'hf : 4'h0;
    nxt_st.wr_n = nxt_st.mem ? lnk.wr_lo_n : 1'b1;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_ff      <= '0;
      st_ff.rs   <= RS_POR;
      st_ff.wr_n <= 1'b1;
      st_ff.rd   <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign lnk.flash_busy = st_ff.busy;
  assign lnk.power_down = power_down_flag;
  assign lnk.ready      = (st_ff.rs == RS_RUN);
  assign turbo_on        = st_ff.turbo;
  assign logic_standby   = st_ff.standby;
  assign clk_to_array    = st_ff.clk_and;
  assign clk_to_mc       = st_ff.clk_mc;
  assign array_addr      = st_ff.a_g;
  assign array_ctl       = st_ff.c_g;
  assign mem_en          = st_ff.mem;
  assign io_en           = st_ff.io;
  assign prim_sector_sel = st_ff.fs;
  assign sec_sector_sel  = st_ff.bs;
  assign flash_wr_n      = st_ff.wr_n;
  assign flash_read_mode = st_ff.rd;
  assign cfg_loaded      = st_ff.cfg;
  assign logic_out_valid = st_ff.outs_valid;
  assign macrocell       = st_ff.mc;
  assign mmap_reg        = st_ff.mmap;
endmodule

/* File: core/prc_host.sv */
// Host end: software registers drive reset pulses and link pins.
// Assumes software port per house bus; no wait states.
`timescale 1ns/1ps
module prc_host #(
  parameter int unsigned POR_CYC = prc_pkg::POR_CYC
) (
  input  wire logic       ref_clk,  // System clock
  input  wire logic       rst,      // Async reset
  input  wire logic [3:0] addr,     // Register address
  input  wire logic [7:0] wdata,    // Write data
  input  wire logic       wr,       // Write strobe
  input  wire logic       rd,       // Read strobe
  output logic [7:0]      rdata,    // Read data, next cycle
  prc_link_if.host        lnk       // Link to device
);
  typedef struct packed {
    logic [19:0] pulse;
    logic [7:0]  apd;
    logic [7:0]  pmd;
    logic        we0;
    logic        we2;
    logic [7:0]  rdat;
    logic [7:0]  pins;
    logic [7:0]  alo;
    logic        lclk;
    logic [1:0]  ldiv;
  } prc_host_s;
  prc_host_s st_ff, nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.we0 = 1'b0;
    nxt_st.we2 = 1'b0;
    nxt_st.rdat = 8'h00;
    if (st_ff.pulse != '0) nxt_st.pulse = st_ff.pulse - 20'h1;
    // Logic clock stands low unless software lets it run
    if (st_ff.apd[prc_pkg::APD_CLK_RUN]) begin
      if (st_ff.ldiv == 2'(prc_pkg::LCLK_HALF - 1)) begin
        nxt_st.ldiv = 2'h0;
        nxt_st.lclk = ~st_ff.lclk;
      end else begin
        nxt_st.ldiv = st_ff.ldiv + 2'h1;
      end
    end else begin
      nxt_st.ldiv = 2'h0;
      nxt_st.lclk = 1'b0;
    end
    if (wr) begin
      case (addr)
        prc_pkg::A_PM0: begin
          nxt_st.pmd = wdata;
          nxt_st.we0 = 1'b1;
        end
        prc_pkg::A_PM2: begin
          nxt_st.pmd = wdata;
          nxt_st.we2 = 1'b1;
        end
        prc_pkg::A_APD_CFG: nxt_st.apd = wdata;
        prc_pkg::A_PINS:    nxt_st.pins = wdata;
        prc_pkg::A_ADDR:    nxt_st.alo = wdata;
        prc_pkg::A_CMD: begin
          if (wdata[prc_pkg::CMD_POR])       nxt_st.pulse = 20'(POR_CYC);
          else if (wdata[prc_pkg::CMD_WARM]) nxt_st.pulse = 20'(prc_pkg::WARM_CYC);
        end
        default: ;
      endcase
    end
    if (rd) begin
      case (addr)
        prc_pkg::A_APD_CFG: nxt_st.rdat = st_ff.apd;
        prc_pkg::A_STATUS:  nxt_st.rdat = {5'h0, lnk.flash_busy, lnk.power_down, lnk.ready};
        default:            nxt_st.rdat = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_ff       <= '0;
      st_ff.pulse <= 20'(POR_CYC);
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata            = st_ff.rdat;
  assign lnk.reset_n      = (st_ff.pulse == '0);
  assign lnk.apd_cfg      = st_ff.apd;
  assign lnk.pm_wdata     = st_ff.pmd;
  assign lnk.pm0_we       = st_ff.we0;
  assign lnk.pm2_we       = st_ff.we2;
  // Bus pins from software registers; reset leaves them idle
  assign lnk.chip_sel_n   = ~st_ff.pins[prc_pkg::PIN_SEL];
  assign lnk.addr_strobe  = st_ff.apd[prc_pkg::APD_POL];
  assign lnk.wr_lo_n      = ~st_ff.pins[prc_pkg::PIN_WR_LO];
  assign lnk.wr_hi        = st_ff.pins[prc_pkg::PIN_WR_HI];
  assign lnk.ctl_in       = st_ff.pins[prc_pkg::PIN_CTL +: 3];
  assign lnk.addr_lo      = st_ff.alo;
  assign lnk.logic_clk_in = st_ff.lclk;
endmodule

/* File: core/prc_link_if.sv */
// Pins between the power/reset controller and the host side.
// Assumes both ends are clocked by the same ref_clk.
`timescale 1ns/1ps
interface prc_link_if;
  logic       reset_n;         // Active-low reset to device
  logic       chip_sel_n;      // Active-low chip select
  logic       addr_strobe;     // Host address strobe
  logic       wr_lo_n;         // Low-byte write strobe, active low
  logic       wr_hi;           // High-byte write strobe
  logic [2:0] ctl_in;          // Control inputs zero..two
  logic [7:0] addr_lo;         // Low address byte
  logic       logic_clk_in;    // Logic clock input, sampled
  logic [7:0] pm_wdata;        // Power-mode register write data
  logic       pm0_we;          // Write power_mode_reg_zero
  logic       pm2_we;          // Write power_mode_reg_two
  logic [7:0] apd_cfg;         // Bit0 enable, bit1 strobe polarity
  logic       flash_busy;      // Flash program/erase running
  logic       power_down;      // power_down_flag
  logic       ready;           // Post-reset wait over
  modport dev (input reset_n, chip_sel_n, addr_strobe, wr_lo_n, wr_hi, ctl_in, addr_lo,
               logic_clk_in, pm_wdata, pm0_we, pm2_we, apd_cfg,
               output flash_busy, power_down, ready);
  modport host (output reset_n, chip_sel_n, addr_strobe, wr_lo_n, wr_hi, ctl_in, addr_lo,
                logic_clk_in, pm_wdata, pm0_we, pm2_we, apd_cfg,
                input flash_busy, power_down, ready);
endinterface

/* File: core/prc_pkg.sv */
// Shared constants for the power and reset control block.
// Assumes a single 250 MHz ref_clk domain on both ends.
package prc_pkg;
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned CLK_PERIOD_PS    = 4000;
  // Timing figures in their own units
  localparam int unsigned IDLE_NS          = 70;
  localparam int unsigned POR_PULSE_US     = 1000;
  localparam int unsigned OPR_WAIT_NS      = 120;
  localparam int unsigned WARM_PULSE_NS    = 150;
  localparam int unsigned ABORT_US         = 25;
  // Least times round up, longest round down
  localparam int unsigned IDLE_CYC  = (IDLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned OPR_CYC   = (OPR_WAIT_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned WARM_CYC  = (WARM_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned POR_CYC   = POR_PULSE_US * CLK_MHZ;
  localparam int unsigned ABORT_CYC = ABORT_US * CLK_MHZ;
  localparam int unsigned APD_LIMIT = 15;
  // Power-mode register zero fields
  localparam int unsigned PM0_TURBO_OFF = 3;
  localparam int unsigned PM0_CLK_AND   = 4;
  localparam int unsigned PM0_CLK_MC    = 5;
  // Power-mode register two fields
  localparam int unsigned PM2_ADDR_LO = 0;
  localparam int unsigned PM2_CTL0    = 2;
  localparam int unsigned PM2_CTL1    = 3;
  localparam int unsigned PM2_CTL2    = 4;
  localparam int unsigned PM2_STROBE  = 5;
  localparam int unsigned PM2_WRH     = 6;
  // Memory-mapping register fields
  localparam int unsigned MM_SRAM_CODE = 0;
  localparam int unsigned MM_PERIPH    = 1;
  // Software register addresses on the host port
  localparam logic [3:0] A_PM0     = 4'h0;
  localparam logic [3:0] A_PM2     = 4'h1;
  localparam logic [3:0] A_APD_CFG = 4'h2;
  localparam logic [3:0] A_CMD     = 4'h3;
  localparam logic [3:0] A_STATUS  = 4'h4;
  localparam logic [3:0] A_MMAP    = 4'h5;
  localparam logic [3:0] A_PINS    = 4'h6;
  localparam logic [3:0] A_ADDR    = 4'h7;
  // Power-down unit setup fields
  localparam int unsigned APD_EN      = 0;
  localparam int unsigned APD_POL     = 1;
  localparam int unsigned APD_CLK_RUN = 2;
  // Logic clock input half period in ref_clk cycles
  localparam int unsigned LCLK_HALF   = 2;
  // Host bus pin register fields, one meaning active
  localparam int unsigned PIN_SEL   = 0;
  localparam int unsigned PIN_WR_LO = 1;
  localparam int unsigned PIN_WR_HI = 2;
  localparam int unsigned PIN_CTL   = 3;
  // Host command bits
  localparam int unsigned CMD_POR  = 0;
  localparam int unsigned CMD_WARM = 1;
  localparam logic [7:0] REG_RST   = 8'h00;
endpackage

/* File: dv/power_reset_control_tb.sv */
// Bench for the host and device ends joined by the link interface.
// Assumes shortened power-on and abort counts set below.
`timescale 1ns/1ps
module power_reset_control_tb;
  localparam int unsigned POR_N   = 50;
  localparam int unsigned ABORT_N = 20;
  logic       ref_clk;
  logic       rst;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       flash_start;
  logic [7:0] mc_eq_state;
  logic       turbo_on, logic_standby, clk_to_array, clk_to_mc, mem_en, io_en;
  logic       flash_wr_n, flash_read_mode, cfg_loaded, logic_out_valid;
  logic [7:0] array_addr, prim_sector_sel, macrocell, mmap_reg, d, v, w, p, a;
  logic       s, lclk_q;
  logic [4:0] array_ctl;
  logic [3:0] sec_sector_sel;
  int         mismatches, check_count, cyc;
  prc_link_if lnk ();
  prc_host #(.POR_CYC(POR_N)) i_prc_host (.ref_clk(ref_clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .lnk(lnk));
  prc_device #(.POR_CYC(POR_N), .ABORT_CYC(ABORT_N)) i_prc_device (.ref_clk(ref_clk),
    .rst(rst), .lnk(lnk), .flash_start(flash_start), .mc_eq_state(mc_eq_state),
    .turbo_on(turbo_on), .logic_standby(logic_standby), .clk_to_array(clk_to_array),
    .clk_to_mc(clk_to_mc), .array_addr(array_addr), .array_ctl(array_ctl), .mem_en(mem_en),
    .io_en(io_en), .prim_sector_sel(prim_sector_sel), .sec_sector_sel(sec_sector_sel),
    .flash_wr_n(flash_wr_n), .flash_read_mode(flash_read_mode), .cfg_loaded(cfg_loaded),
    .logic_out_valid(logic_out_valid), .macrocell(macrocell), .mmap_reg(mmap_reg));
  prc_chk #(.ABORT_CYC(ABORT_N)) i_prc_chk (.ref_clk(ref_clk), .rst(rst),
    .reset_n(lnk.reset_n), .chip_sel_n(lnk.chip_sel_n), .addr_strobe(lnk.addr_strobe),
    .logic_clk_in(lnk.logic_clk_in), .apd_cfg(lnk.apd_cfg), .flash_busy(lnk.flash_busy),
    .power_down(lnk.power_down), .ready(lnk.ready));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic results();
    if (mismatches == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] dv);
    @(posedge ref_clk);
    addr <= a; wdata <= dv; wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] dv);
    @(posedge ref_clk);
    addr <= a; rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 dv = rdata;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wait_ready();
    int k;
    for (k = 0; k < 400 && lnk.ready !== 1'b1; k++) idle(1);
    chk(lnk.ready, 1'b1);
  endtask
  // Gated array inputs: a set bit blocks its group
  function automatic logic [4:0] exp_ctl(input logic [7:0] m, input logic [7:0] pn,
                                         input logic sl);
    return {pn[2] & ~m[6], sl & ~m[5], pn[5] & ~m[4], pn[4] & ~m[3], pn[3] & ~m[2]};
  endfunction
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    lclk_q <= lnk.logic_clk_in;
    if (cyc == 20000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    rst = 1'b1; addr = 4'h0; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
    flash_start = 1'b0; mc_eq_state = 8'h00; mismatches = 0; check_count = 0; cyc = 0;
    void'($urandom(32'h9446));
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    idle(2);
    chk(lnk.reset_n, 1'b0);
    chk(prim_sector_sel, 8'h00);
    chk(sec_sector_sel, 4'h0);
    chk(flash_wr_n, 1'b1);
    wait_ready();
    chk(flash_read_mode, 1'b1);
    chk(cfg_loaded, 1'b1);
    chk(logic_out_valid, 1'b1);
    chk(macrocell, 8'h00);
    chk(mmap_reg, 8'h58);
    chk(turbo_on, 1'b1);
    rd_reg(prc_pkg::A_STATUS, d);
    chk(d, 8'h01);
    rd_reg(4'hf, d);
    chk(d, 8'h00);
    // Both-extreme masks first, then random ones, written back to back
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      w = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      p = (i == 0) ? 8'h3f : (i == 1) ? 8'h00 : 8'($urandom);
      a = 8'($urandom);
      s = 1'($urandom);
      wr_reg(prc_pkg::A_PM0, v);
      wr_reg(prc_pkg::A_PM2, w);
      wr_reg(prc_pkg::A_PINS, p);
      wr_reg(prc_pkg::A_ADDR, a);
      wr_reg(prc_pkg::A_APD_CFG, {5'h0, 1'b1, s, 1'b0});
      idle(4);
      chk(turbo_on, !v[3]);
      chk(clk_to_array, lclk_q & !v[4]);
      chk(clk_to_mc, lclk_q & !v[5]);
      chk(array_addr, w[0] ? 8'h00 : a);
      chk(array_ctl, exp_ctl(w, p, s));
      chk(mem_en, p[0]);
      chk(io_en, p[0]);
      chk(prim_sector_sel, p[0] ? 8'hff : 8'h00);
      chk(sec_sector_sel, p[0] ? 4'hf : 4'h0);
      chk(flash_wr_n, p[0] ? !p[1] : 1'b1);
      chk(logic_out_valid, 1'b1);
    end
    // Logic clock stopped so the inputs can go quiet
    wr_reg(prc_pkg::A_APD_CFG, 8'h00);
    wr_reg(prc_pkg::A_PM0, 8'h08);
    idle(25);
    chk(logic_standby, 1'b1);
    wr_reg(prc_pkg::A_PM0, 8'h00);
    idle(4);
    chk(logic_standby, 1'b0);
    wr_reg(prc_pkg::A_PM0, 8'h08);
    flash_start <= 1'b1;
    @(posedge ref_clk);
    flash_start <= 1'b0;
    mc_eq_state <= 8'($urandom) | 8'h01;
    rd_reg(prc_pkg::A_STATUS, d);
    chk(d[2], 1'b1);
    wr_reg(prc_pkg::A_CMD, 8'h02);
    idle(4);
    chk(lnk.reset_n, 1'b0);
    chk(macrocell, mc_eq_state);
    chk(logic_out_valid, 1'b1);
    wait_ready();
    chk(lnk.flash_busy, 1'b0);
    chk(flash_read_mode, 1'b1);
    chk(turbo_on, 1'b0);
    chk(mmap_reg, 8'h58);
    wr_reg(prc_pkg::A_PM2, 8'h00);
    wr_reg(prc_pkg::A_ADDR, 8'ha5);
    wr_reg(prc_pkg::A_PM0, 8'h38);
    idle(4);
    chk(array_addr, 8'ha5);
    wr_reg(prc_pkg::A_APD_CFG, 8'h05);
    rd_reg(prc_pkg::A_APD_CFG, d);
    chk(d, 8'h05);
    for (int k = 0; k < 300 && lnk.power_down !== 1'b1; k++) idle(1);
    idle(2);
    chk(lnk.power_down, 1'b1);
    chk(array_addr, 8'h00);
    chk(mem_en, 1'b0);
    chk(clk_to_array, 1'b0);
    wr_reg(prc_pkg::A_PINS, 8'h01);
    idle(3);
    chk(lnk.power_down, 1'b0);
    chk(mem_en, 1'b1);
    chk(io_en, 1'b1);
    wr_reg(prc_pkg::A_PINS, 8'h00);
    // A long pulse on reset_n is still a warm reset to the device
    wr_reg(prc_pkg::A_CMD, 8'h01);
    idle(4);
    chk(lnk.power_down, 1'b0);
    chk(turbo_on, 1'b0);
    chk(macrocell, mc_eq_state);
    chk(prim_sector_sel, 8'h00);
    // Writes during reset must be refused
    wr_reg(prc_pkg::A_PM0, 8'h00);
    wait_ready();
    idle(3);
    chk(turbo_on, 1'b0);
    chk(mmap_reg, 8'h58);
    // Second power-on reset in mid-run clears what warm reset keeps
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    idle(2);
    chk(macrocell, 8'h00);
    chk(lnk.ready, 1'b0);
    wait_ready();
    chk(turbo_on, 1'b1);
    chk(mmap_reg, 8'h58);
    results();
  end
endmodule

/* File: dv/prc_chk.sv */
// Concurrent checks on the link between the host and device ends.
// Assumes one ref_clk domain and rst as the async reset of both ends.
`timescale 1ns/1ps
module prc_chk #(
  parameter int unsigned ABORT_CYC = prc_pkg::ABORT_CYC
) (
  input wire logic       ref_clk,      // System clock
  input wire logic       rst,          // Async reset
  input wire logic       reset_n,      // Device reset, active low
  input wire logic       chip_sel_n,   // Chip select, active low
  input wire logic       addr_strobe,  // Host address strobe
  input wire logic       logic_clk_in, // Logic clock input
  input wire logic [7:0] apd_cfg,      // Power-down unit setup
  input wire logic       flash_busy,   // Flash cycle running
  input wire logic       power_down,   // Power-down flag
  input wire logic       ready         // Recovery over
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic        clk_prev_ff;
  logic [15:0] idle_cnt_ff;
  logic [15:0] abort_cnt_ff;
  // Idle edges seen by a counter of our own, reset on any strobe activity
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      clk_prev_ff  <= 1'b0;
      idle_cnt_ff  <= 16'h0000;
      abort_cnt_ff <= 16'h0000;
    end else begin
      clk_prev_ff <= logic_clk_in;
      if (!apd_cfg[0] || addr_strobe != apd_cfg[1]) idle_cnt_ff <= 16'h0000;
      else if (logic_clk_in && !clk_prev_ff && idle_cnt_ff != 16'hffff)
        idle_cnt_ff <= idle_cnt_ff + 16'h0001;
      abort_cnt_ff <= (!reset_n && flash_busy) ? abort_cnt_ff + 16'h0001 : 16'h0000;
    end
  end
  rdy_in_reset_a: assert property (!reset_n |=> !ready)
    else $error("ready high while reset held");
  rdy_hold_a: assert property ($rose(reset_n) |-> !ready [*8])
    else $error("ready rose too soon after reset release");
  rdy_bound_a: assert property ($rose(reset_n) |-> ##[1:30] ready)
    else $error("ready late after reset release");
  pdn_enable_a: assert property ($rose(power_down) |-> $past(apd_cfg[0]))
    else $error("power down raised while disabled");
  pdn_level_a: assert property (
    $rose(power_down) |-> $past(addr_strobe) == $past(apd_cfg[1]))
    else $error("power down raised with strobe away from idle level");
  pdn_count_a: assert property ($rose(power_down) |-> idle_cnt_ff >= 16'h000f)
    else $error("power down raised before fifteen idle clocks");
  pdn_wake_a: assert property (
    power_down && (!chip_sel_n || !reset_n) |-> ##[1:2] !power_down)
    else $error("power down not left on select or reset");
  abort_time_a: assert property (abort_cnt_ff <= ABORT_CYC + 2)
    else $error("flash cycle not aborted by reset in time");
endmodule
